/* File: tb/scsa_monitor.sv */
// Port checker for the sync adjust block
`timescale 1ns/1ps
`include "scsa_defs.vh"
module scsa_monitor #(
  parameter MS_CYCLES = 10
) (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Sync inputs
  input wire [5:0] pulse_di,
  input wire pulse_virtual,
  input wire msg_valid,
  input wire [3:0] msg_source,
  input wire [26:0] msg_time_ms,
  input wire msg_is_net,
  // Status
  input wire [26:0] time_of_day_ms,
  input wire [3:0] active_sync_source,
  input wire [15:0] sync_event_count
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Message taken, status shows one edge after the update
  sequence s_msg;
    msg_valid ##1 1'b1;
  endsequence
  chk_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not idle");
  chk_reset_clear: assert property ($fell(srst) |-> time_of_day_ms == 27'h0
    && active_sync_source == 4'h0 && sync_event_count == 16'h0)
    else $error("status not clear after reset");
  chk_count_step: assert property (s_msg |=>
    (sync_event_count - $past(sync_event_count)) == 16'h1)
    else $error("message not counted once");
  chk_count_plus1: assert property ($changed(sync_event_count) |->
    sync_event_count == $past(sync_event_count) + 16'h1)
    else $error("count moved by other than one");
  chk_src_follow: assert property (s_msg |=>
    active_sync_source == $past(msg_source, 2))
    else $error("source not taken from message");
  chk_src_with_cnt: assert property ($changed(active_sync_source) &&
    active_sync_source != 4'h0 |-> $changed(sync_event_count))
    else $error("source changed without event");
  chk_no_back_step: assert property (time_of_day_ms <
    $past(time_of_day_ms) |-> $past(time_of_day_ms) - time_of_day_ms > 27'd3999)
    else $error("small backward time step");
  chk_fwd_rate: assert property (time_of_day_ms > $past(time_of_day_ms)
    |-> time_of_day_ms - $past(time_of_day_ms) <= 27'd2 ||
    time_of_day_ms - $past(time_of_day_ms) >= 27'd3999)
    else $error("time jumped by a mid-size amount");
  chk_count_read: assert property ($past(reg_rd) &&
    $past(reg_addr) == `SCSA_REG_COUNT |-> reg_rdata == {16'h0, sync_event_count})
    else $error("count read mismatch");
  chk_unmapped_zero: assert property ($past(reg_rd) &&
    $past(reg_addr) > 8'h20 |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // scsa_monitor

/* File: tb/scsa_source_model.sv */
// External time source: minute pulses and decoded sync messages
`timescale 1ns/1ps
module scsa_source_model (
  // Clock
  input wire clk_sys,
  // Minute pulse pins
  output reg [5:0] pulse_di,
  output reg pulse_virtual,
  // Sync message
  output reg msg_valid,
  output reg [3:0] msg_source,
  output reg [26:0] msg_time_ms,
  output reg msg_is_net
);
  // Idle lines low, message fields hold a junk pattern
  initial begin
    pulse_di = 6'h0;
    pulse_virtual = 1'b0;
    msg_valid = 1'b0;
    msg_source = 4'h5;
    msg_time_ms = 27'h5555555;
    msg_is_net = 1'b0;
  end
  // Strobe held for cnt cycles; released fields invert so no stale copy
  task send(input [3:0] s, input [26:0] t, input n, input integer cnt);
    begin
      msg_source <= s;
      msg_time_ms <= t;
      msg_is_net <= n;
      msg_valid <= 1'b1;
      repeat (cnt) @(posedge clk_sys);
      msg_valid <= 1'b0;
      msg_source <= ~s;
      msg_time_ms <= ~t;
      msg_is_net <= ~n;
    end
  endtask
  // Pulse on a one-hot mask {virtual, pins}, high for cyc cycles
  task pulse(input [6:0] m, input integer cyc);
    begin
      {pulse_virtual, pulse_di} <= m;
      repeat (cyc) @(posedge clk_sys);
      {pulse_virtual, pulse_di} <= 7'h0;
    end
  endtask
endmodule // scsa_source_model

/* File: tb/scsa_top_bench.sv */
// Self-checking bench for the sync adjust block
`timescale 1ns/1ps
module scsa_top_bench;
  reg clk_sys = 1'b0;
  reg srst = 1'b1;
  reg [7:0] reg_addr = 8'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  wire [31:0] reg_rdata;
  wire [5:0] pulse_di;
  wire pulse_virtual, msg_valid, msg_is_net;
  wire [3:0] msg_source, active_sync_source;
  wire [26:0] msg_time_ms, time_of_day_ms;
  wire [15:0] sync_event_count;
  integer failures = 0;
  integer checked = 0;
  integer cycles = 0;
  reg [31:0] d, c, t;
  integer i;
  // One ms is four cycles to keep second-scale runs short
  scsa_top #(.MS_CYCLES(4)) DUT (.clk_sys(clk_sys), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pulse_di(pulse_di),
    .pulse_virtual(pulse_virtual), .msg_valid(msg_valid),
    .msg_source(msg_source), .msg_time_ms(msg_time_ms),
    .msg_is_net(msg_is_net), .time_of_day_ms(time_of_day_ms),
    .active_sync_source(active_sync_source),
    .sync_event_count(sync_event_count));
  scsa_source_model src (.clk_sys(clk_sys), .pulse_di(pulse_di),
    .pulse_virtual(pulse_virtual), .msg_valid(msg_valid),
    .msg_source(msg_source), .msg_time_ms(msg_time_ms),
    .msg_is_net(msg_is_net));
  // 100 MHz clock; ceiling above the expected 91.5k cycles, under 100k
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 99000) begin
      failures = failures + 1;
      end_sim;
    end
  end
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] v);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      // Read data stands only in the cycle after the strobe
      #1 v = reg_rdata;
    end
  endtask
  task chk(input [8*8-1:0] n, input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("BAD %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // Time checks allow a few ms of phase slack
  task near(input [8*8-1:0] n, input [31:0] e, input [31:0] g,
            input integer tol);
    integer df;
    begin
      df = g - e;
      checked = checked + 1;
      if (^g === 1'bx || df > tol || df < -tol) begin
        failures = failures + 1;
        $display("BAD %0s expected %0d seen %0d", n, e, g);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    begin
      for (i = 0; i < 40; i = i + 4) begin
        if (i != 16) begin
          rd(i, d);
          chk("regrst", 32'h0, d);
        end
      end
    end
  endtask
  // Interval one second, run three seconds each way
  task t_drift;
    begin
      wr(8'h00, 32'h2);
      wr(8'h04, 32'h1);
      @(posedge clk_sys) #1 t = time_of_day_ms;
      repeat (12000) @(posedge clk_sys);
      #1 near("lag", t + 3003, time_of_day_ms, 1);
      wr(8'h00, 32'h3);
      @(posedge clk_sys) #1 t = time_of_day_ms;
      repeat (12000) @(posedge clk_sys);
      #1 near("lead", t + 2997, time_of_day_ms, 1);
      wr(8'h04, 32'h0);
    end
  endtask
  // Network message with offset, zone one hour and seasonal hour
  task t_net;
    begin
      wr(8'h08, 32'd5000);
      wr(8'h0c, 32'h4);
      wr(8'h00, 32'h12);
      @(posedge clk_sys);
      src.send(4'h2, 27'd1000000, 1'b1, 1);
      repeat (2) @(posedge clk_sys);
      #1 near("nettime", 32'd8205000, time_of_day_ms, 2);
      rd(8'h14, d);
      chk("source", 32'h2, d);
      rd(8'h18, d);
      chk("count", 32'h1, d);
      rd(8'h1c, d);
      chk("dev", 32'hffff8001, d);
      rd(8'h20, d);
      chk("filtered_deviation", 32'h0, d);
      wr(8'h04, 32'h7b);
      rd(8'h04, d);
      chk("intv", 32'h0, d);
      wr(8'h00, 32'h13);
      rd(8'h00, d);
      chk("ctrl", 32'h12, d);
    end
  endtask
  // Every selector value; selector none must ignore pin one
  task t_pulse;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        wr(8'h00, (i << 4) | 32'h2);
        rd(8'h18, c);
        #1 t = time_of_day_ms;
        t = (t + 30000) / 60000 * 64'd60000 + 5000;
        @(posedge clk_sys);
        src.pulse((i == 0) ? 7'h1 : 7'h1 << (i - 1), 220);
        repeat (6) @(posedge clk_sys);
        if (i == 1) begin
          #1 near("minute", t + 57, time_of_day_ms, 3);
        end
        rd(8'h18, d);
        chk("pcount", c + (i != 0), d);
      end
      rd(8'h14, d);
      chk("psrc", 32'h1, d);
    end
  endtask
  // Timecode with system 300 ms ahead: no back step, clamped filter
  task t_lead;
    begin
      @(posedge clk_sys) #1 t = time_of_day_ms;
      @(posedge clk_sys);
      src.send(4'ha, t - 5300, 1'b0, 1);
      rd(8'h1c, d);
      near("leaddev", 32'd300, d, 2);
      rd(8'h20, d);
      chk("filtered_deviation", 32'h7d, d);
      rd(8'h14, d);
      chk("tcsrc", 32'ha, d);
      rd(8'h00, d);
      chk("sign", 32'h1, d & 32'h1);
      rd(8'h04, d);
      if (d[31])
        d = -d;
      chk("learn", 32'd9994, d);
    end
  endtask
  // Back-to-back burst of 65536 messages brings the count full circle
  task t_wrap;
    begin
      rd(8'h18, c);
      @(posedge clk_sys);
      src.send(4'h3, 27'h0, 1'b0, 65536);
      repeat (3) @(posedge clk_sys);
      rd(8'h18, d);
      chk("wrap", c, d);
    end
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset;
    t_drift;
    t_net;
    t_pulse;
    t_lead;
    t_wrap;
    end_sim;
  end
endmodule // scsa_top_bench
bind scsa_top scsa_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.*);

/* File: verilog/scsa_defs.vh */
// Constants for the system clock sync and adjust block
`ifndef SCSA_DEFS_VH
`define SCSA_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SCSA_REG_CTRL 8'h00
`define SCSA_REG_INTERVAL 8'h04
`define SCSA_REG_OFFSET 8'h08
`define SCSA_REG_ZONE 8'h0c
`define SCSA_REG_TIME 8'h10
`define SCSA_REG_SOURCE 8'h14
`define SCSA_REG_COUNT 8'h18
`define SCSA_REG_DEV 8'h1c
`define SCSA_REG_FILTERED_DEVIATION 8'h20

// ----------------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------------
`define SCSA_CTRL_SIGN_BIT 0
`define SCSA_CTRL_SEASON_BIT 1
`define SCSA_CTRL_SEL_LSB 4
`define SCSA_CTRL_SEL_MSB 6
`define SCSA_SEL_NONE 3'h0
`define SCSA_SEL_VIRTUAL 3'h7
`define SCSA_RST_INTERVAL 16'h0000
`define SCSA_RST_OFFSET 25'h0000000
`define SCSA_RST_ZONE 8'h00

// ----------------------------------------------------------------------
// Sync source codes
// ----------------------------------------------------------------------
`define SCSA_SRC_INTERNAL 4'h0
`define SCSA_SRC_PULSE 4'h1
`define SCSA_SRC_TIMECODE 4'ha

// ----------------------------------------------------------------------
// Timing and arithmetic constants
// ----------------------------------------------------------------------
`define SCSA_CLK_MHZ 100
`define SCSA_TICK_US 1000
`define SCSA_MS_CYCLES (`SCSA_CLK_MHZ * `SCSA_TICK_US)
`define SCSA_TIMEOUT_S 90
`define SCSA_TIMEOUT_MS (`SCSA_TIMEOUT_S * 1000)
`define SCSA_DAY_MS 30'sh5265c00
`define SCSA_HALF_DAY_MS 30'sh2932e00
`define SCSA_MINUTE_MS 27'hea60
`define SCSA_HALF_MINUTE_MS 27'h7530
`define SCSA_QUARTER_HOUR_MS 30'shdbba0
`define SCSA_HOUR_MS 30'sh36ee80
`define SCSA_STEP_LIMIT_MS 30'shfa0
`define SCSA_DEV_LIMIT 30'sh7fff
`define SCSA_FILT_LIMIT 30'sh7d
`define SCSA_INTERVAL_MAX 14'h2710
`define SCSA_SLOW_SPACING 4'h9

`endif

/* File: verilog/scsa_top.v */
// System time of day with external sync, offset, drift trim and deviation
//
// Behaviour
// - Nonzero interval: shift clock one millisecond every interval seconds.
// - Lead makes each periodic step retard; lag makes it advance.
// - During external sync, learn drift and update interval and sign.
// - External sync owns time, interval and sign; software writes ignored.
// - Errors under four seconds never step time backward; lead slows.
// - Pulse selector: none, physical inputs one to six, or virtual.
// - Rising edge of selected pulse rounds time to nearest minute.
// - Signed millisecond offset is added to every received sync time.
// - Each sync updates source; ninety quiet seconds revert to internal.
// - Source code: internal, pulse, protocol syncs, or timecode.
// - Sync event counter counts every sync, sixteen bits, wrapping.
// - Hold signed system minus source deviation, saturated at 32767 ms.
// - Report filtered deviation within 125 ms, the correction applied.
// - Zone in quarter hours, plus or minus fifteen, applied to network UTC.
// - Seasonal enable adds one hour to network-synchronised time.
`timescale 1ns/1ps
`include "scsa_defs.vh"

module scsa_top #(
  parameter MS_CYCLES = `SCSA_MS_CYCLES
) (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Minute pulse sources
  input wire [5:0] pulse_di,
  input wire pulse_virtual,
  // Decoded protocol or timecode sync message
  input wire msg_valid,
  input wire [3:0] msg_source,
  input wire [26:0] msg_time_ms,
  input wire msg_is_net,
  // Status
  output reg [26:0] time_of_day_ms,
  output reg [3:0] active_sync_source,
  output reg [15:0] sync_event_count
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Fold any value within two days either side back into one day
  function [26:0] scsa_norm;
    input signed [29:0] v;
    reg signed [29:0] t;
    begin
      t = v;
      if (t < 0) t = t + `SCSA_DAY_MS;
      if (t < 0) t = t + `SCSA_DAY_MS;
      if (t >= `SCSA_DAY_MS) t = t - `SCSA_DAY_MS;
      if (t >= `SCSA_DAY_MS) t = t - `SCSA_DAY_MS;
      scsa_norm = t[26:0];
    end
  endfunction

  // Symmetric saturation
  function signed [29:0] scsa_clamp;
    input signed [29:0] v;
    input signed [29:0] lim;
    begin
      if (v > lim) scsa_clamp = lim;
      else if (v < -lim) scsa_clamp = -lim;
      else scsa_clamp = v;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg [16:0] div_ff;
  reg [9:0] ms_in_sec_ff;
  reg [13:0] sec_cnt_ff;
  reg [3:0] space_ff;
  reg [16:0] quiet_ff;
  reg signed [15:0] corr_ff;
  reg [26:0] time_ff;
  reg [3:0] src_ff;
  reg [15:0] count_ff;
  reg signed [15:0] dev_ff;
  reg signed [7:0] filtered_deviation_ff;
  reg drift_sign_ff;
  reg seasonal_shift_enable_ff;
  reg [2:0] pulse_sync_select_ff;
  reg signed [15:0] adjust_interval_ff;
  reg signed [24:0] sync_offset_ff;
  reg signed [7:0] zone_offset_hours_ff;
  reg [5:0] s1_ff;
  reg [5:0] s2_ff;
  reg [5:0] s3_ff;
  reg [5:0] lvl_ff;
  reg sel_prev_ff;

  // ----------------------------------------------------------------------
  // Millisecond and second enables
  // ----------------------------------------------------------------------
  wire ms_tick = (div_ff == MS_CYCLES - 1);
  wire sec_tick = ms_tick & (ms_in_sec_ff == 10'h3e7);
  wire external = (src_ff != `SCSA_SRC_INTERNAL);

  always @(posedge clk_sys) begin
    if (srst) begin
      div_ff <= 17'h00000;
      ms_in_sec_ff <= 10'h000;
    end else begin
      div_ff <= ms_tick ? 17'h00000 : div_ff + 17'h00001;
      if (ms_tick)
        ms_in_sec_ff <= sec_tick ? 10'h000 : ms_in_sec_ff + 10'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Pulse input conditioning
  // ----------------------------------------------------------------------
  // Pins cross in through three stages; a level is taken once the last two
  // agree, which rejects a single-cycle glitch on the edge
  always @(posedge clk_sys) begin
    if (srst) begin
      s1_ff <= 6'h00;
      s2_ff <= 6'h00;
      s3_ff <= 6'h00;
      lvl_ff <= 6'h00;
    end else begin
      s1_ff <= pulse_di;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff | s3_ff));
    end
  end

  // Selector picks none, one physical input or the virtual source
  reg sel_lvl;
  always @* begin
    if (pulse_sync_select_ff == `SCSA_SEL_NONE)
      sel_lvl = 1'b0;
    else if (pulse_sync_select_ff == `SCSA_SEL_VIRTUAL)
      sel_lvl = pulse_virtual;
    else
      sel_lvl = lvl_ff[pulse_sync_select_ff - 3'h1];
  end

  always @(posedge clk_sys) begin
    if (srst)
      sel_prev_ff <= 1'b0;
    else
      sel_prev_ff <= sel_lvl;
  end

  wire pulse_edge = sel_lvl & ~sel_prev_ff;

  // ----------------------------------------------------------------------
  // Sync target and deviation
  // ----------------------------------------------------------------------
  reg [26:0] minute_rem;
  reg signed [29:0] raw_src;
  reg signed [29:0] shift;
  reg [26:0] target;
  reg signed [29:0] diff;
  reg signed [29:0] filt;
  reg small_err;
  reg signed [29:0] dev_sat;

  always @* begin
    minute_rem = time_ff % `SCSA_MINUTE_MS;
    // Message wins when both arrive together; the pulse is dropped
    if (msg_valid)
      raw_src = {3'h0, msg_time_ms};
    else if (minute_rem >= `SCSA_HALF_MINUTE_MS)
      raw_src = {3'h0, time_ff - minute_rem} + {3'h0, `SCSA_MINUTE_MS};
    else
      raw_src = {3'h0, time_ff - minute_rem};
    shift = {{5{sync_offset_ff[24]}}, sync_offset_ff};
    if (msg_valid & msg_is_net) begin
      shift = shift + {{22{zone_offset_hours_ff[7]}}, zone_offset_hours_ff}
        * `SCSA_QUARTER_HOUR_MS;
      if (seasonal_shift_enable_ff)
        shift = shift + `SCSA_HOUR_MS;
    end
    target = scsa_norm(raw_src + shift);
    // Positive means the system clock leads the source
    diff = {3'h0, time_ff} - {3'h0, target};
    if (diff > `SCSA_HALF_DAY_MS) diff = diff - `SCSA_DAY_MS;
    if (diff < -`SCSA_HALF_DAY_MS) diff = diff + `SCSA_DAY_MS;
    small_err = (diff < `SCSA_STEP_LIMIT_MS) &&
      (diff > -`SCSA_STEP_LIMIT_MS);
    filt = scsa_clamp(diff, `SCSA_FILT_LIMIT);
    dev_sat = scsa_clamp(diff, `SCSA_DEV_LIMIT);
  end

  wire sync_evt = msg_valid | pulse_edge;

  // ----------------------------------------------------------------------
  // Auto-adjust interval timing
  // ----------------------------------------------------------------------
  wire [15:0] iv_abs = adjust_interval_ff[15] ? -adjust_interval_ff :
    adjust_interval_ff;
  wire [13:0] iv_mag = iv_abs[13:0];
  wire auto_step = sec_tick && (iv_mag != 14'h0000) &&
    (sec_cnt_ff + 14'h0001 >= iv_mag);

  always @(posedge clk_sys) begin
    if (srst)
      sec_cnt_ff <= 14'h0000;
    else if (auto_step)
      sec_cnt_ff <= 14'h0000;
    else if (sec_tick)
      sec_cnt_ff <= sec_cnt_ff + 14'h0001;
  end

  // ----------------------------------------------------------------------
  // Time of day and pending correction
  // ----------------------------------------------------------------------
  // A positive pending correction is paid out one extra millisecond per
  // tick; a negative one withholds one tick in every ten, so the reported
  // time never runs backward while a small lead decays
  reg signed [15:0] nxt_corr;
  reg [26:0] nxt_time;
  reg [1:0] inc;

  always @* begin
    nxt_corr = corr_ff;
    inc = 2'h1;
    if (corr_ff > 0) begin
      inc = 2'h2;
      nxt_corr = corr_ff - 16'sh0001;
    end else if (corr_ff < 0 && space_ff == 4'h0) begin
      inc = 2'h0;
      nxt_corr = corr_ff + 16'sh0001;
    end
    nxt_time = scsa_norm({3'h0, time_ff} + {28'h0000000, inc});
  end

  wire sw_time_wr = reg_wr && reg_addr == `SCSA_REG_TIME && !external;

  always @(posedge clk_sys) begin
    if (srst) begin
      time_ff <= 27'h0000000;
      corr_ff <= 16'sh0000;
      space_ff <= 4'h0;
    end else if (sync_evt) begin
      if (small_err) begin
        corr_ff <= -filt[15:0];
      end else begin
        time_ff <= target;
        corr_ff <= 16'sh0000;
      end
    end else if (sw_time_wr) begin
      time_ff <= scsa_norm({3'h0, reg_wdata[26:0]});
      corr_ff <= 16'sh0000;
    end else begin
      if (ms_tick) begin
        time_ff <= nxt_time;
        space_ff <= (space_ff == `SCSA_SLOW_SPACING) ? 4'h0 :
          space_ff + 4'h1;
      end
      // Periodic step: lead retards, lag advances
      if (auto_step)
        corr_ff <= (ms_tick ? nxt_corr : corr_ff) +
          (drift_sign_ff ? -16'sh0001 : 16'sh0001);
      else if (ms_tick)
        corr_ff <= nxt_corr;
    end
  end

  // ----------------------------------------------------------------------
  // Source indication, counters and deviation
  // ----------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      src_ff <= `SCSA_SRC_INTERNAL;
      quiet_ff <= 17'h00000;
      count_ff <= 16'h0000;
      dev_ff <= 16'sh0000;
      filtered_deviation_ff <= 8'sh00;
    end else if (sync_evt) begin
      src_ff <= msg_valid ? msg_source : `SCSA_SRC_PULSE;
      quiet_ff <= 17'h00000;
      count_ff <= count_ff + 16'h0001;
      dev_ff <= dev_sat[15:0];
      filtered_deviation_ff <= small_err ? filt[7:0] : 8'sh00;
    end else if (ms_tick && external) begin
      if (quiet_ff == `SCSA_TIMEOUT_MS - 1) begin
        src_ff <= `SCSA_SRC_INTERNAL;
        quiet_ff <= 17'h00000;
      end else begin
        quiet_ff <= quiet_ff + 17'h00001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Settings, drift learning and register writes
  // ----------------------------------------------------------------------
  // Learning moves the interval by one second per sync, except that zero jumps to 10000 and
  // 10000 drops to zero on an opposite error; slow, but one noisy message cannot wreck a well-trained interval
  wire learn = sync_evt && small_err && external && diff != 0;
  wire lead_err = (diff > 0);

  always @(posedge clk_sys) begin
    if (srst) begin
      drift_sign_ff <= 1'b0;
      seasonal_shift_enable_ff <= 1'b0;
      pulse_sync_select_ff <= `SCSA_SEL_NONE;
      adjust_interval_ff <= `SCSA_RST_INTERVAL;
      sync_offset_ff <= `SCSA_RST_OFFSET;
      zone_offset_hours_ff <= `SCSA_RST_ZONE;
    end else begin
      if (learn) begin
        if (iv_mag == 14'h0000) begin
          drift_sign_ff <= lead_err;
          adjust_interval_ff <= {2'h0, `SCSA_INTERVAL_MAX};
        end else if (drift_sign_ff == lead_err) begin
          // Same direction: correct more often
          if (iv_mag > 14'h0001)
            adjust_interval_ff <= {2'h0, iv_mag - 14'h0001};
        end else if (iv_mag < `SCSA_INTERVAL_MAX) begin
          adjust_interval_ff <= {2'h0, iv_mag + 14'h0001};
        end else begin
          adjust_interval_ff <= 16'sh0000;
        end
      end else if (reg_wr) begin
        if (reg_addr == `SCSA_REG_CTRL) begin
          if (!external)
            drift_sign_ff <= reg_wdata[`SCSA_CTRL_SIGN_BIT];
          seasonal_shift_enable_ff <= reg_wdata[`SCSA_CTRL_SEASON_BIT];
          pulse_sync_select_ff <=
            reg_wdata[`SCSA_CTRL_SEL_MSB:`SCSA_CTRL_SEL_LSB];
        end else if (reg_addr == `SCSA_REG_INTERVAL) begin
          if (!external)
            adjust_interval_ff <= reg_wdata[15:0];
        end else if (reg_addr == `SCSA_REG_OFFSET) begin
          sync_offset_ff <= reg_wdata[24:0];
        end else if (reg_addr == `SCSA_REG_ZONE) begin
          zone_offset_hours_ff <= reg_wdata[7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register read, one cycle after the strobe
  // ----------------------------------------------------------------------
  reg [31:0] nxt_rdata;

  always @* begin
    nxt_rdata = 32'h00000000;
    if (reg_addr == `SCSA_REG_CTRL)
      nxt_rdata = {25'h0000000, pulse_sync_select_ff, 2'h0,
        seasonal_shift_enable_ff, drift_sign_ff};
    else if (reg_addr == `SCSA_REG_INTERVAL)
      nxt_rdata = {{16{adjust_interval_ff[15]}}, adjust_interval_ff};
    else if (reg_addr == `SCSA_REG_OFFSET)
      nxt_rdata = {{7{sync_offset_ff[24]}}, sync_offset_ff};
    else if (reg_addr == `SCSA_REG_ZONE)
      nxt_rdata = {{24{zone_offset_hours_ff[7]}}, zone_offset_hours_ff};
    else if (reg_addr == `SCSA_REG_TIME)
      nxt_rdata = {5'h00, time_ff};
    else if (reg_addr == `SCSA_REG_SOURCE)
      nxt_rdata = {28'h0000000, src_ff};
    else if (reg_addr == `SCSA_REG_COUNT)
      nxt_rdata = {16'h0000, count_ff};
    else if (reg_addr == `SCSA_REG_DEV)
      nxt_rdata = {{16{dev_ff[15]}}, dev_ff};
    else if (reg_addr == `SCSA_REG_FILTERED_DEVIATION)
      nxt_rdata = {{24{filtered_deviation_ff[7]}}, filtered_deviation_ff};
  end

  always @(posedge clk_sys) begin
    if (srst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
      reg_rdata <= nxt_rdata;
    else
      reg_rdata <= 32'h00000000;
  end

  // ----------------------------------------------------------------------
  // Status outputs, registered copies
  // ----------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      time_of_day_ms <= 27'h0000000;
      active_sync_source <= `SCSA_SRC_INTERNAL;
      sync_event_count <= 16'h0000;
    end else begin
      time_of_day_ms <= time_ff;
      active_sync_source <= src_ff;
      sync_event_count <= count_ff;
    end
  end

endmodule // scsa_top
